// *** rtl/bhc_map.svh ***
/*
 * Register offsets, field positions, reset values and timing counts
 * of the battery-domain hibernation controller.
 * Assumes inclusion by bare name from rtl/.
 */
`ifndef BHC_MAP_SVH
`define BHC_MAP_SVH

// Register offsets
`define BHC_OFS_CLKDIV    4'h0
`define BHC_OFS_OSCCTL    4'h1
`define BHC_OFS_WAKE      4'h2
`define BHC_OFS_HIBSTART  4'h3
`define BHC_OFS_POWERDET  4'h4
`define BHC_OFS_XFERCTL   4'h5
`define BHC_OFS_XFERSTAT  4'h6
`define BHC_OFS_PORTFUNC  4'h7
`define BHC_OFS_PULLUP    4'h8
`define BHC_OFS_DIR       4'h9
`define BHC_OFS_PINS      4'hA
`define BHC_OFS_OUTDATA   4'hB
`define BHC_OFS_PSEUDO_OD 4'hC
`define BHC_OFS_ALARM     4'hD

// Field positions
`define BHC_BIT_START       0
`define BHC_BIT_OSC_STOP    0
`define BHC_BIT_OSC_LINK    1
`define BHC_BIT_WAKE_REQ    0
`define BHC_BIT_XFER_RECALL 0
`define BHC_BIT_XFER_SAVE   1
`define BHC_BIT_FN_REG      0
`define BHC_BIT_FN_WAKE     1

// Reset values
`define BHC_RST_CLKDIV    8'h07
`define BHC_RST_OSCCTL    2'h1
`define BHC_RST_PORTFUNC  4'hC
`define BHC_RST_OUTDATA   4'hF
`define BHC_RST_PSEUDO_OD 2'h3

// Transfer clock: peripheral clock over divider plus this offset
`define BHC_DIV_OFFSET    9'h002
// Transfer clock edges per batch transfer (one per port register)
`define BHC_XFER_STEPS    3'h5

`endif

// *** rtl/bhc_pkg.sv ***
/*
 * Types of the battery-domain hibernation controller.
 * Assumes no other package.
 */
package bhc_pkg;
    typedef enum logic [1:0] {
        BHC_RUN,
        BHC_HIBERNATE
    } bhc_power_t;

    typedef enum logic [1:0] {
        BHC_XFER_IDLE,
        BHC_XFER_RECALL,
        BHC_XFER_SAVE
    } bhc_xfer_t;
endpackage

// *** rtl/bhc_retention.sv ***
/*
 * Battery-backed retention register for the port settings.
 * Assumes a load strobe from the transfer sequencer and the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bhc_retention #(
    parameter int WIDTH = 18
) (
    // Clock and battery-domain reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Load and data
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_data,
    input  wire logic [WIDTH-1:0] reset_value,
    output logic      [WIDTH-1:0] held
);
    logic [WIDTH-1:0] next_held;

    always_comb begin
        next_held = held;
        if (load) begin
            next_held = load_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            held <= reset_value;
        end else begin
            held <= next_held;
        end
    end
endmodule
`default_nettype wire

// *** rtl/bhc_top.sv ***
/*
 * Battery-domain hibernation controller: regulator gate, wake sources,
 * oscillator control and batch transfer of port settings.
 * Assumes a plain register port with read data one cycle after the strobe.
 */
// Functional notes
// (RQ1) Writing start bit drives regulator control low at once.
// (RQ2) Software clears alarm and wakeup request before starting hibernation.
// (RQ3) Alarm or wakeup during hibernation drives regulator control high.
// (RQ4) Software sets wakeup function select to use the wake input.
// (RQ5) Software sets regulator function select to use the gate output.
// (RQ6) Entry accepted without wake sources; only power cycle returns.
// (RQ7) After return, power-on, alarm and wakeup flags are readable.
// (RQ8) Software finishes all work before writing the start bit.
// (RQ9) Oscillator and clock keep running without main supply.
// (RQ10) Linked mode stops oscillation on deep standby at supply return.
// (RQ11) No built-in oscillator settling wait exists.
// (RQ12) Software brings oscillator up in the documented order.
// (RQ13) Software uses linked mode briefly for a settled start.
// (RQ14) Software input setup order ends with transfer and wait.
// (RQ15) Software output setup order ends with transfer and wait.
// (RQ16) Pseudo-open-drain only exists for regulator and wakeup lines.
// (RQ17) Software peripheral setup order ends with transfer and wait.
// (RQ18) Wakeup request registers on a rising wakeup edge.
// (RQ19) Transfer busy flag is one from start to transfer end.
// (RQ20) Transfer clock is peripheral clock over divider plus two.
// (RQ21) Gate level and wake flags live in battery-powered logic.
`timescale 1ns/1ps
`default_nettype none
`include "bhc_map.svh"
module bhc_top (
    // Clock and resets
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       battery_reset,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Wake sources and standby
    input  wire logic       alarm_event,
    input  wire logic       deep_standby,
    // Battery I/O lines
    input  wire logic [3:0] port_in,
    output logic      [3:0] port_out,
    output logic      [3:0] port_oe_n,
    // Regulator gate and oscillator
    output logic            regulator_control_out,
    output logic            oscillator_run
);
    // Battery-domain state
    bhc_pkg::bhc_power_t power_state, next_power_state;
    logic       wakeup_request_flag, next_wakeup_request_flag;
    logic       alarm_match_flag, next_alarm_match_flag;
    logic       power_on_flag, next_power_on_flag;
    logic       wake_prev, next_wake_prev;
    logic       oscillator_link_enable, next_oscillator_link_enable;
    logic       oscillator_stop_control, next_oscillator_stop_control;
    logic       linked_stopped, next_linked_stopped;
    // Main-domain buffers, loaded by reset rather than battery reset
    logic [7:0] transfer_clock_divider, next_transfer_clock_divider;
    logic [3:0] buf_func, next_buf_func, buf_pull, next_buf_pull;
    logic [3:0] buf_dir, next_buf_dir, buf_out, next_buf_out;
    logic [1:0] buf_pod, next_buf_pod;
    logic [7:0] next_reg_rdata;
    // Transfer sequencer
    bhc_pkg::bhc_xfer_t xfer_state, next_xfer_state;
    logic [8:0] div_count, next_div_count;
    logic [2:0] step, next_step;
    logic       save_load;
    logic       transfer_busy_flag;
    logic [17:0] held, reset_held, buf_all;
    logic       wake_rise;
    logic       hib_write;
    logic       first_load, next_first_load;

    function automatic logic is_write(input logic [3:0] ofs);
        return reg_write && (reg_addr == ofs);
    endfunction

    assign hib_write = is_write(`BHC_OFS_HIBSTART) && reg_wdata[`BHC_BIT_START];
    assign wake_rise = port_in[3] && !wake_prev && held[`BHC_BIT_FN_WAKE]; // see (RQ18)
    assign transfer_busy_flag = (xfer_state != bhc_pkg::BHC_XFER_IDLE);    // see (RQ19)
    assign buf_all = {buf_pod, buf_out, buf_dir, buf_pull, buf_func};
    assign reset_held = {`BHC_RST_PSEUDO_OD, `BHC_RST_OUTDATA, 4'h0, 4'h0, `BHC_RST_PORTFUNC};

    // Power gate and wake flags, reset on battery reset only
    always_comb begin
        next_power_state = power_state;
        next_wake_prev = port_in[3];
        next_wakeup_request_flag = wakeup_request_flag;
        next_alarm_match_flag = alarm_match_flag;
        next_power_on_flag = power_on_flag;
        if (is_write(`BHC_OFS_WAKE) && reg_wdata[`BHC_BIT_WAKE_REQ]) begin
            next_wakeup_request_flag = 1'b0;
        end
        if (is_write(`BHC_OFS_ALARM) && reg_wdata[0]) begin
            next_alarm_match_flag = 1'b0;
        end
        if (is_write(`BHC_OFS_POWERDET) && reg_wdata[0]) begin
            next_power_on_flag = 1'b0;
        end
        if (wake_rise) begin
            next_wakeup_request_flag = 1'b1;                             // see (RQ7)
        end
        if (alarm_event) begin
            next_alarm_match_flag = 1'b1;                                // see (RQ7)
        end
        case (power_state)
            bhc_pkg::BHC_RUN: begin
                if (hib_write) begin
                    next_power_state = bhc_pkg::BHC_HIBERNATE;           // see (RQ1) (RQ6)
                end
            end
            bhc_pkg::BHC_HIBERNATE: begin
                if (wake_rise || alarm_event) begin
                    next_power_state = bhc_pkg::BHC_RUN;                 // see (RQ3)
                end
            end
            default: next_power_state = bhc_pkg::BHC_RUN;
        endcase
    end

    // Regulator low in the write cycle itself
    assign regulator_control_out = held[`BHC_BIT_FN_REG] ?
        ((power_state == bhc_pkg::BHC_RUN) && !hib_write) : buf_out_held(held); // see (RQ1)

    function automatic logic buf_out_held(input logic [17:0] h);
        return h[14];
    endfunction

    // Oscillator control, battery domain
    always_comb begin
        next_oscillator_link_enable = oscillator_link_enable;
        next_oscillator_stop_control = oscillator_stop_control;
        next_linked_stopped = linked_stopped;
        if (is_write(`BHC_OFS_OSCCTL)) begin
            next_oscillator_link_enable = reg_wdata[`BHC_BIT_OSC_LINK];
            next_oscillator_stop_control = reg_wdata[`BHC_BIT_OSC_STOP];
            next_linked_stopped = 1'b0;
        end else if (oscillator_link_enable && deep_standby &&
                     (power_state == bhc_pkg::BHC_HIBERNATE) &&
                     (wake_rise || alarm_event)) begin
            next_linked_stopped = 1'b1;                                  // see (RQ10)
        end
    end

    // Free-running unless stopped; no settling wait inside
    assign oscillator_run = oscillator_link_enable ? !linked_stopped
                                                   : !oscillator_stop_control; // see (RQ9) (RQ11)

    always_ff @(posedge clk) begin
        if (battery_reset) begin
            power_state <= bhc_pkg::BHC_RUN;                             // see (RQ21)
            wake_prev <= 1'b0;
            wakeup_request_flag <= 1'b0;
            alarm_match_flag <= 1'b0;
            power_on_flag <= 1'b1;
            oscillator_link_enable <= 1'b0;
            oscillator_stop_control <= 1'(`BHC_RST_OSCCTL);
            linked_stopped <= 1'b0;
        end else begin
            power_state <= next_power_state;
            wake_prev <= next_wake_prev;
            wakeup_request_flag <= next_wakeup_request_flag;
            alarm_match_flag <= next_alarm_match_flag;
            power_on_flag <= next_power_on_flag;
            oscillator_link_enable <= next_oscillator_link_enable;
            oscillator_stop_control <= next_oscillator_stop_control;
            linked_stopped <= next_linked_stopped;
        end
    end

    // Buffers, divider and batch transfer
    always_comb begin
        next_transfer_clock_divider = transfer_clock_divider;
        next_buf_func = buf_func;
        next_buf_pull = buf_pull;
        next_buf_dir = buf_dir;
        next_buf_out = buf_out;
        next_buf_pod = buf_pod;
        next_xfer_state = xfer_state;
        next_div_count = div_count;
        next_step = step;
        save_load = 1'b0;
        if (is_write(`BHC_OFS_CLKDIV)) next_transfer_clock_divider = reg_wdata;
        if (is_write(`BHC_OFS_PORTFUNC)) next_buf_func = reg_wdata[3:0];
        if (is_write(`BHC_OFS_PULLUP)) next_buf_pull = reg_wdata[3:0];
        if (is_write(`BHC_OFS_DIR)) next_buf_dir = reg_wdata[3:0];
        if (is_write(`BHC_OFS_OUTDATA)) next_buf_out = reg_wdata[3:0];
        if (is_write(`BHC_OFS_PSEUDO_OD)) next_buf_pod = reg_wdata[1:0]; // see (RQ16)
        case (xfer_state)
            bhc_pkg::BHC_XFER_IDLE: begin
                next_div_count = 9'h000;
                next_step = 3'h0;
                if (is_write(`BHC_OFS_XFERCTL) && reg_wdata[`BHC_BIT_XFER_RECALL]) begin
                    next_xfer_state = bhc_pkg::BHC_XFER_RECALL;          // see (RQ19)
                end else if (is_write(`BHC_OFS_XFERCTL) && reg_wdata[`BHC_BIT_XFER_SAVE]) begin
                    next_xfer_state = bhc_pkg::BHC_XFER_SAVE;            // see (RQ19)
                end
            end
            bhc_pkg::BHC_XFER_RECALL, bhc_pkg::BHC_XFER_SAVE: begin
                next_div_count = div_count + 9'h001;
                if (div_count == {1'b0, transfer_clock_divider} + `BHC_DIV_OFFSET - 9'h001) begin
                    next_div_count = 9'h000;                             // see (RQ20)
                    next_step = step + 3'h1;
                    if (step == `BHC_XFER_STEPS - 3'h1) begin
                        next_xfer_state = bhc_pkg::BHC_XFER_IDLE;        // see (RQ19)
                        if (xfer_state == bhc_pkg::BHC_XFER_SAVE) begin
                            save_load = 1'b1;
                        end else begin
                            {next_buf_pod, next_buf_out, next_buf_dir,
                             next_buf_pull, next_buf_func} = held;
                        end
                    end
                end
            end
            default: next_xfer_state = bhc_pkg::BHC_XFER_IDLE;
        endcase
    end

    bhc_retention #(
        .WIDTH (18)
    ) u_retention (
        .clk         (clk),
        .reset       (battery_reset),
        .load        (save_load || first_load),
        .load_data   (first_load ? reset_held : buf_all),
        .reset_value (reset_held),
        .held        (held)
    );

    // Seed retention with its reset values once after battery reset
    assign next_first_load = 1'b0;
    always_ff @(posedge clk) begin
        if (battery_reset) begin
            first_load <= 1'b1;
        end else begin
            first_load <= next_first_load;
        end
    end

    // Pin drive from retained settings; pseudo-open-drain on lines 2 and 3
    always_comb begin
        port_out = held[15:12];
        port_oe_n = ~held[11:8];
        for (int i = 2; i < 4; i++) begin
            if (held[16 + i - 2] && !held[12 + i]) begin
                port_out[i] = held[12 + i];                              // see (RQ16)
            end else if (held[16 + i - 2]) begin
                port_oe_n[i] = 1'b1;
            end
        end
        port_oe_n[2] = held[`BHC_BIT_FN_REG] ? regulator_control_out : port_oe_n[2];
        port_out[2] = held[`BHC_BIT_FN_REG] ? 1'b0 : port_out[2];
    end

    // Read data, one cycle after the strobe
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                `BHC_OFS_CLKDIV:    next_reg_rdata = transfer_clock_divider;
                `BHC_OFS_OSCCTL:    next_reg_rdata = {6'h00, oscillator_link_enable,
                                                      oscillator_stop_control};
                `BHC_OFS_WAKE:      next_reg_rdata = {7'h00, wakeup_request_flag}; // see (RQ7)
                `BHC_OFS_POWERDET:  next_reg_rdata = {7'h00, power_on_flag};       // see (RQ7)
                `BHC_OFS_ALARM:     next_reg_rdata = {7'h00, alarm_match_flag};    // see (RQ7)
                `BHC_OFS_XFERSTAT:  next_reg_rdata = {7'h00, transfer_busy_flag};
                `BHC_OFS_PORTFUNC:  next_reg_rdata = {4'h0, buf_func};
                `BHC_OFS_PULLUP:    next_reg_rdata = {4'h0, buf_pull};
                `BHC_OFS_DIR:       next_reg_rdata = {4'h0, buf_dir};
                `BHC_OFS_PINS:      next_reg_rdata = {4'h0, port_in};
                `BHC_OFS_OUTDATA:   next_reg_rdata = {4'h0, buf_out};
                `BHC_OFS_PSEUDO_OD: next_reg_rdata = {6'h00, buf_pod};
                default:            next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            transfer_clock_divider <= `BHC_RST_CLKDIV;
            buf_func <= `BHC_RST_PORTFUNC;
            buf_pull <= 4'h0;
            buf_dir <= 4'h0;
            buf_out <= `BHC_RST_OUTDATA;
            buf_pod <= `BHC_RST_PSEUDO_OD;
            xfer_state <= bhc_pkg::BHC_XFER_IDLE;
            div_count <= 9'h000;
            step <= 3'h0;
            reg_rdata <= 8'h00;
        end else begin
            transfer_clock_divider <= next_transfer_clock_divider;
            buf_func <= next_buf_func;
            buf_pull <= next_buf_pull;
            buf_dir <= next_buf_dir;
            buf_out <= next_buf_out;
            buf_pod <= next_buf_pod;
            xfer_state <= next_xfer_state;
            div_count <= next_div_count;
            step <= next_step;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Checks
    property p_gate_low;
        @(posedge clk) disable iff (battery_reset)
        (hib_write && held[`BHC_BIT_FN_REG] && !wake_rise && !alarm_event)
            |=> (power_state == bhc_pkg::BHC_HIBERNATE);
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("no hibernation entry"); // see (RQ1)

    property p_gate_immediate;
        @(posedge clk) disable iff (battery_reset)
        (hib_write && held[`BHC_BIT_FN_REG]) |-> !regulator_control_out;
    endproperty
    a_gate_immediate: assert property (p_gate_immediate) else $error("gate not low"); // see (RQ1)

    property p_wake_return;
        @(posedge clk) disable iff (battery_reset)
        (power_state == bhc_pkg::BHC_HIBERNATE && (alarm_event || wake_rise))
            |=> (power_state == bhc_pkg::BHC_RUN);
    endproperty
    a_wake_return: assert property (p_wake_return) else $error("no wake return"); // see (RQ3)

    property p_stay_asleep;
        @(posedge clk) disable iff (battery_reset)
        (power_state == bhc_pkg::BHC_HIBERNATE && !alarm_event && !wake_rise)
            |=> (power_state == bhc_pkg::BHC_HIBERNATE);
    endproperty
    a_stay_asleep: assert property (p_stay_asleep) else $error("spurious wake"); // see (RQ6)

    property p_wake_flag;
        @(posedge clk) disable iff (battery_reset)
        wake_rise |=> wakeup_request_flag;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake flag lost"); // see (RQ18)

    property p_alarm_flag;
        @(posedge clk) disable iff (battery_reset)
        alarm_event |=> alarm_match_flag;
    endproperty
    a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag lost"); // see (RQ7)

    property p_busy_start;
        @(posedge clk) disable iff (reset)
        (!transfer_busy_flag && is_write(`BHC_OFS_XFERCTL) && (reg_wdata[1:0] != 2'h0))
            |=> transfer_busy_flag;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not set"); // see (RQ19)

    property p_busy_min;
        @(posedge clk) disable iff (reset)
        $rose(transfer_busy_flag) && (transfer_clock_divider == 8'h00)
            |-> transfer_busy_flag [*8] ##1 transfer_busy_flag ##1 transfer_busy_flag
                ##1 !transfer_busy_flag;
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("transfer length wrong"); // see (RQ20)

    property p_link_stop;
        @(posedge clk) disable iff (battery_reset)
        (oscillator_link_enable && deep_standby && !is_write(`BHC_OFS_OSCCTL) &&
         (power_state == bhc_pkg::BHC_HIBERNATE) && (wake_rise || alarm_event))
            |=> !oscillator_run;
    endproperty
    a_link_stop: assert property (p_link_stop) else $error("osc not stopped"); // see (RQ10)
endmodule
`default_nettype wire

// *** testbench/bhc_regulator_model.sv ***
/*
 * External regulator standby input and wake source model.
 * Assumes the pseudo-open-drain regulator line has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module bhc_regulator_model (
    // Device side
    input  wire logic       regulator_control_out,
    input  wire logic [3:0] port_out,
    input  wire logic [3:0] port_oe_n,
    // Bench commands
    input  wire logic       wake_level,
    input  wire logic [1:0] gpio_level,
    // Far side
    output logic            supply_on,
    output logic      [3:0] port_in
);
    // Standby input low removes supply, high restores it
    assign supply_on = regulator_control_out;
    // Pulled-up regulator line, low only while driven low
    assign port_in[2] = (!port_oe_n[2] && !port_out[2]) ? 1'b0 : 1'b1;
    // Wake source gives a rising edge on request
    assign port_in[3] = wake_level;
    // General lines follow the driver, else the bench level
    assign port_in[1:0] = (~port_oe_n[1:0] & port_out[1:0]) | (port_oe_n[1:0] & gpio_level);
endmodule
`default_nettype wire

// *** testbench/bhc_top_test.sv ***
/*
 * Self-checking bench of the hibernation controller.
 * Assumes the regulator model on the far side of the gate output.
 */
`timescale 1ns/1ps
`default_nettype none
module bhc_top_test;
    logic       clk, reset, battery_reset, reg_write, reg_read;
    logic       alarm_event, deep_standby, wake_level, supply_on;
    logic       regulator_control_out, oscillator_run;
    logic [1:0] gpio_level;
    logic [3:0] reg_addr, port_in, port_out, port_oe_n;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    int         n_errors, checked, n, k;

    bhc_top dut_u (.clk(clk), .reset(reset), .battery_reset(battery_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .alarm_event(alarm_event),
        .deep_standby(deep_standby), .port_in(port_in), .port_out(port_out),
        .port_oe_n(port_oe_n), .regulator_control_out(regulator_control_out),
        .oscillator_run(oscillator_run));
    bhc_regulator_model model_u (.regulator_control_out(regulator_control_out),
        .port_out(port_out), .port_oe_n(port_oe_n), .wake_level(wake_level),
        .gpio_level(gpio_level), .supply_on(supply_on), .port_in(port_in));

    always #5 clk = ~clk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Bounded wait for supply (sel 0) or oscillator (sel 1) level
    task automatic wait_sig(input int sel, input logic lvl, input int lim);
        for (k = 0; k < lim && (sel ? oscillator_run : supply_on) !== lvl; k++) begin
            @(posedge clk);
            #1;
        end
        chk1(sel ? "oscillator run" : "supply", lvl, sel ? oscillator_run : supply_on);
        if ((sel ? oscillator_run : supply_on) !== lvl) stop_test;
    endtask

    // Start a batch transfer and count busy cycles by back-to-back reads
    task automatic xfer(input logic [7:0] ctl, input int len);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= 4'h5;
        reg_wdata <= ctl;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        reg_addr  <= 4'h6;
        n = 0;
        rd_val = 8'h01;
        for (k = 0; k < 600 && rd_val !== 8'h00; k++) begin
            @(posedge clk);
            #1 rd_val = reg_rdata;
            if (rd_val === 8'h01) n++;
        end
        @(posedge clk);
        reg_read <= 1'b0;
        chk8("busy end", 8'h00, rd_val);
        chk8("busy length", 8'(len), 8'(n));
        if (rd_val !== 8'h00) stop_test;
    endtask

    // Clear wake sources, then enter hibernation
    task automatic hib;
        wr(4'hD, 8'h01);
        wr(4'h2, 8'h01);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= 4'h3;
        reg_wdata <= 8'h01;
        #1 chk1("gate in start cycle", 1'b0, regulator_control_out);
        @(posedge clk);
        reg_write <= 1'b0;
        #1 chk1("supply after start", 1'b0, supply_on);
        chk1("regulator line low", 1'b0, port_in[2]);
    endtask

    task automatic alarm_pulse;
        @(posedge clk);
        alarm_event <= 1'b1;
        @(posedge clk);
        alarm_event <= 1'b0;
        #1 chk1("supply after alarm", 1'b1, supply_on);
    endtask

    initial begin
        clk = 0;
        reset = 1;
        battery_reset = 1;
        {reg_write, reg_read, alarm_event, deep_standby, wake_level} = '0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        gpio_level = 2'b11;
        n_errors = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        battery_reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(4'h4, rd_val);
        chk8("power-on flag", 8'h01, rd_val);
        rd(4'hC, rd_val);
        chk8("pseudo-od reset", 8'h03, rd_val);
        wr(4'hC, 8'hFF);
        rd(4'hC, rd_val);
        chk8("pseudo-od width", 8'h03, rd_val);
        rd(4'hF, rd_val);
        chk8("unmapped read", 8'h00, rd_val);
        chk1("supply after reset", 1'b1, supply_on);
        $display("test reset_state done");
        wr(4'h7, 8'h03);
        xfer(8'h02, 45);
        wr(4'h0, 8'h00);
        xfer(8'h01, 10);
        rd(4'h7, rd_val);
        chk8("recall port func", 8'h03, rd_val);
        wr(4'h0, 8'h07);
        $display("test transfer done");
        wr(4'h1, 8'h00);
        wait_sig(1, 1'b1, 4);
        hib;
        repeat (20) @(posedge clk);
        #1 chk1("supply held off", 1'b0, supply_on);
        chk1("osc during hibernation", 1'b1, oscillator_run);
        alarm_pulse;
        rd(4'hD, rd_val);
        chk8("alarm flag", 8'h01, rd_val);
        rd(4'h2, rd_val);
        chk8("wake flag clear", 8'h00, rd_val);
        chk1("osc independent", 1'b1, oscillator_run);
        $display("test alarm_wake done");
        hib;
        @(posedge clk);
        wake_level <= 1'b1;
        wait_sig(0, 1'b1, 4);
        rd(4'h2, rd_val);
        chk8("wake flag", 8'h01, rd_val);
        wake_level <= 1'b0;
        $display("test wakeup_edge done");
        deep_standby <= 1'b1;
        wr(4'h1, 8'h02);
        hib;
        chk1("osc linked asleep", 1'b1, oscillator_run);
        alarm_pulse;
        wait_sig(1, 1'b0, 8);
        deep_standby <= 1'b0;
        wr(4'h1, 8'h00);
        wait_sig(1, 1'b1, 4);
        $display("test linked_stop done");
        wr(4'h7, 8'h01);
        wr(4'h9, 8'h03);
        wr(4'hB, 8'h0D);
        xfer(8'h02, 45);
        rd(4'hA, rd_val);
        chk8("pin levels", 8'h05, rd_val);
        hib;
        @(posedge clk);
        wake_level <= 1'b1;
        repeat (10) @(posedge clk);
        #1 chk1("no wake source", 1'b0, supply_on);
        @(posedge clk);
        wake_level <= 1'b0;
        reset <= 1'b1;
        battery_reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        battery_reset <= 1'b0;
        wait_sig(0, 1'b1, 4);
        rd(4'h4, rd_val);
        chk8("power-on after cycle", 8'h01, rd_val);
        $display("test no_source done");
        stop_test;
    end
endmodule
`default_nettype wire
